// >>> core/fcad_decoder.sv
// Purpose: Decodes the CPU's flash command write sequences into operations.
// Assumes: Writes are synchronous to mclk; the array engine reports done or fail.
// Notes:   Writes while busy are ignored; a pulse lasts one enabled cycle.
// Contract
// - Recommended-zero address bits are checked only in the seventh write of protection commands.
// - Block erase takes the block from the sixth write, any address inside.
// - Erase block chosen only by upper bits separating the blocks.
// - Page programming takes the page from the fourth write address.
// - Protection programming selects the bit by the seventh write address.
// - Seventh write: bit18 zero, bits16-11 zero, bits 17,10,9 give block 0-5.
// - Protection erase selects the group by the seventh write address.
// - Bits 18:17 select group: 00 blocks 0-3, 01 blocks 4-5.
// - Protection erase always clears the whole group, never one block.
// - User boot: blocks 4,5,3,2,1,0 from zero, sizes 32,32,64,128,128,128 KB.
// - Single boot: same order at its base; block 0 start taken as printed.
// - Command addresses with upper byte 0x54 or 0x55 are both accepted.
// - Done flag low while an operation runs; stays low after failure.
`timescale 1ns/1ps
`include "fcad_cfg.svh"

module fcad_decoder
    import fcad_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    // CPU write port
    input  wire logic        wrEn,
    input  wire logic [31:0] wrAddr,
    input  wire logic [31:0] wrData,
    // Boot mode and array engine status
    input  wire logic        singleBoot,
    input  wire logic        opDone,
    input  wire logic        opFail,
    // Decoded operation
    output      logic        readReset,
    output      logic        opStart,
    output      fcad_op_type opKind,
    output      logic [5:0]  opBlockMask,
    output      logic [31:0] program_page_addr,
    output      logic        pageWordValid,
    output      logic [31:0] pageWordAddr,
    output      logic [31:0] pageWordData,
    output      logic        auto_op_done_flag
);
    // ======================================================================
    // State
    // ======================================================================
    fcad_state_type state_ff, nxt_state;
    logic [7:0]     seqCode_ff;
    logic [1:0]     wordIdx_ff;
    logic           failed_ff;
    logic           readReset_ff, opStart_ff, pageWordValid_ff, doneFlag_ff;
    fcad_op_type    opKind_ff, nxt_opKind;
    logic [5:0]     opMask_ff, nxt_opMask;
    logic [31:0]    pageAddr_ff, pageWordAddr_ff, pageWordData_ff;

    // ======================================================================
    // Write decode
    // ======================================================================
    wire logic [7:0] cmdAddr  = wrAddr[`FCAD_CMD_HI:`FCAD_CMD_LO];
    wire logic [7:0] code     = wrData[7:0];
    // Low two bits gate each write; command byte, block and protection fields are decoded.
    wire logic       wrTake   = clkEn && wrEn && doneFlag_ff && (wrAddr[1:0] == 2'h0);
    wire logic       addrA    = (cmdAddr == `FCAD_ADDR_CMD_A0) || (cmdAddr == `FCAD_ADDR_CMD_A1);
    wire logic       addrB    = (cmdAddr == `FCAD_ADDR_CMD_B);
    wire logic       blkHit;
    wire logic [2:0] blkNum;
    wire logic [2:0] pbaNum   = {wrAddr[17], wrAddr[10], wrAddr[9]};
    wire logic       pbaOk    = !wrAddr[18] && (wrAddr[`FCAD_PBA_FIX_HI:`FCAD_PBA_FIX_LO] == 6'h00)
                                && (pbaNum <= `FCAD_MAX_PROT_BLOCK);
    wire logic [5:0] grpMask  = wrAddr[17] ? `FCAD_GROUP_HIGH : `FCAD_GROUP_LOW;
    wire logic       grpOk    = !wrAddr[18];
    wire logic       lastWord = (state_ff == ST_PAGE) && (wordIdx_ff == `FCAD_PAGE_WORDS);
    wire logic       pageWr   = wrTake && ((state_ff == ST_PAGE)
                                || ((state_ff == ST_W4) && (seqCode_ff == `FCAD_CODE_PROG)));

    fcad_blk_map u_blk_map (
        .addr       (wrAddr),
        .singleBoot (singleBoot),
        .blkHit     (blkHit),
        .blkNum     (blkNum)
    );

    // ======================================================================
    // Sequence decode
    // ======================================================================
    always_comb begin
        nxt_state  = state_ff;
        nxt_opKind = OP_NONE;
        nxt_opMask = 6'h00;
        if (wrTake) begin
            nxt_state = ST_IDLE;
            case (state_ff)
                ST_IDLE: begin
                    if (addrA && code == `FCAD_CODE_UNLOCK1) nxt_state = ST_W2;
                end
                ST_W2: begin
                    if (addrB && code == `FCAD_CODE_UNLOCK2) nxt_state = ST_W3;
                end
                ST_W3: begin
                    if (addrA && (code == `FCAD_CODE_PROG || code == `FCAD_CODE_ERASE ||
                                  code == `FCAD_CODE_PROT_PROG || code == `FCAD_CODE_PROT_ERASE)) begin
                        nxt_state = ST_W4;
                    end
                end
                ST_W4: begin
                    if (seqCode_ff == `FCAD_CODE_PROG) begin
                        nxt_state = ST_PAGE;
                    end else if (addrA && code == `FCAD_CODE_UNLOCK1) begin
                        nxt_state = ST_W5;
                    end
                end
                ST_W5: begin
                    if (addrB && code == `FCAD_CODE_UNLOCK2) nxt_state = ST_W6;
                end
                ST_W6: begin
                    if (seqCode_ff == `FCAD_CODE_ERASE) begin
                        if (addrA && code == `FCAD_CODE_CHIP) begin
                            nxt_opKind = OP_CHIP_ERASE;
                            nxt_opMask = `FCAD_ALL_BLOCKS;
                        end else if (code == `FCAD_CODE_BLOCK && blkHit) begin
                            nxt_opKind = OP_BLOCK_ERASE;
                            nxt_opMask = fcad_onehot(blkNum);
                        end
                    end else if (addrA && code == seqCode_ff) begin
                        nxt_state = ST_W7;
                    end
                end
                ST_W7: begin
                    if (code == seqCode_ff && seqCode_ff == `FCAD_CODE_PROT_PROG && pbaOk) begin
                        nxt_opKind = OP_PROT_PROG;
                        nxt_opMask = fcad_onehot(pbaNum);
                    end else if (code == seqCode_ff && seqCode_ff == `FCAD_CODE_PROT_ERASE && grpOk) begin
                        nxt_opKind = OP_PROT_ERASE;
                        nxt_opMask = grpMask;
                    end
                end
                ST_PAGE: begin
                    if (lastWord) begin
                        nxt_opKind = OP_PAGE_PROG;
                    end else begin
                        nxt_state = ST_PAGE;
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    wire logic isReset = wrTake && (state_ff == ST_W3) && addrA && (code == `FCAD_CODE_RESET);

    // ======================================================================
    // Registers
    // ======================================================================
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_ff   <= ST_IDLE;
            seqCode_ff <= 8'h00;
            wordIdx_ff <= 2'h0;
        end else if (clkEn) begin
            state_ff   <= nxt_state;
            if (wrTake && state_ff == ST_W3) seqCode_ff <= code;
            if (pageWr) wordIdx_ff <= (state_ff == ST_PAGE) ? wordIdx_ff + 2'h1 : 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            readReset_ff <= 1'b0;
            opStart_ff   <= 1'b0;
            opKind_ff    <= OP_NONE;
            opMask_ff    <= 6'h00;
        end else if (clkEn) begin
            readReset_ff <= isReset;
            opStart_ff   <= (nxt_opKind != OP_NONE);
            if (nxt_opKind != OP_NONE) begin
                opKind_ff <= nxt_opKind;
                opMask_ff <= nxt_opMask;
            end
        end
    end

    // The page base comes from the fourth write; later words follow it upward.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pageAddr_ff      <= 32'h0000_0000;
            pageWordValid_ff <= 1'b0;
            pageWordAddr_ff  <= 32'h0000_0000;
            pageWordData_ff  <= 32'h0000_0000;
        end else if (clkEn) begin
            pageWordValid_ff <= pageWr;
            if (pageWr) begin
                pageWordData_ff <= wrData;
                if (state_ff == ST_W4) begin
                    pageAddr_ff     <= wrAddr;
                    pageWordAddr_ff <= wrAddr;
                end else begin
                    pageWordAddr_ff <= pageWordAddr_ff + 32'h0000_0004;
                end
            end
        end
    end

    // A failure holds the flag low until reset.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            doneFlag_ff <= `FCAD_DONE_RESET;
            failed_ff   <= 1'b0;
        end else if (clkEn) begin
            if (opFail) failed_ff <= 1'b1;
            if (nxt_opKind != OP_NONE) begin
                doneFlag_ff <= 1'b0;
            end else if (opDone && !opFail && !failed_ff) begin
                doneFlag_ff <= 1'b1;
            end
        end
    end

    assign readReset         = readReset_ff;
    assign opStart           = opStart_ff;
    assign opKind            = opKind_ff;
    assign opBlockMask       = opMask_ff;
    assign program_page_addr = pageAddr_ff;
    assign pageWordValid     = pageWordValid_ff;
    assign pageWordAddr      = pageWordAddr_ff;
    assign pageWordData      = pageWordData_ff;
    assign auto_op_done_flag = doneFlag_ff;

    // ======================================================================
    // Checks
    // ======================================================================
    low_bits_a: assert property (@(posedge mclk) disable iff (!resetn)
        (clkEn && wrEn && wrAddr[1:0] != 2'h0) |=> (state_ff == $past(state_ff)) && !opStart)
        else $error("write with nonzero low address bits was taken");

    busy_on_start_a: assert property (@(posedge mclk) disable iff (!resetn)
        opStart |-> !auto_op_done_flag)
        else $error("operation started but done flag is high");

    fail_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
        failed_ff |-> ##1 (!auto_op_done_flag || $past(auto_op_done_flag)) && !$rose(auto_op_done_flag))
        else $error("done flag rose after a failure");

    erase_group_a: assert property (@(posedge mclk) disable iff (!resetn)
        (opStart && opKind == OP_PROT_ERASE) |-> (opBlockMask == `FCAD_GROUP_LOW || opBlockMask == `FCAD_GROUP_HIGH))
        else $error("protection erase did not select a whole group");

    group_sel_a: assert property (@(posedge mclk) disable iff (!resetn)
        (wrTake && state_ff == ST_W7 && seqCode_ff == `FCAD_CODE_PROT_ERASE && code == `FCAD_CODE_PROT_ERASE
         && wrAddr[18:17] == 2'h1) |=> opStart && opBlockMask == `FCAD_GROUP_HIGH)
        else $error("group 01 did not select blocks four and five");

    prot_bit_a: assert property (@(posedge mclk) disable iff (!resetn)
        (wrTake && state_ff == ST_W7 && seqCode_ff == `FCAD_CODE_PROT_PROG && code == `FCAD_CODE_PROT_PROG
         && pbaOk) |=> opStart && opKind == OP_PROT_PROG && opBlockMask == fcad_onehot($past(pbaNum)))
        else $error("protection bit programming selected the wrong block");

    block_onehot_a: assert property (@(posedge mclk) disable iff (!resetn)
        (opStart && opKind == OP_BLOCK_ERASE) |-> $onehot(opBlockMask))
        else $error("block erase did not select exactly one block");

    user_map_a: assert property (@(posedge mclk) disable iff (!resetn)
        (!singleBoot && wrAddr[31:16] == 16'h0001) |-> blkHit && blkNum == 3'h3)
        else $error("user boot map misplaced block three");

    page_walk_a: assert property (@(posedge mclk) disable iff (!resetn)
        (pageWr && state_ff == ST_W4) |=> pageWordValid && pageWordAddr == program_page_addr)
        else $error("first page word not at the page address");

    cmd_pattern_a: assert property (@(posedge mclk) disable iff (!resetn)
        (wrTake && state_ff == ST_IDLE && cmdAddr == `FCAD_ADDR_CMD_A1 && code == `FCAD_CODE_UNLOCK1)
        |=> state_ff == ST_W2)
        else $error("0x55 command address was refused");

endmodule // fcad_decoder

// >>> core/fcad_cfg.svh
// Purpose: Constants for the flash command address decoder.
// Assumes: Word bus writes from the CPU; writes with address bits [1:0] nonzero are ignored.
// Notes:   Definitions only.
`ifndef FCAD_CFG_SVH
`define FCAD_CFG_SVH

// ==========================================================================
// Command address patterns and command codes
// ==========================================================================
`define FCAD_ADDR_CMD_A0      8'h54
`define FCAD_ADDR_CMD_A1      8'h55
`define FCAD_ADDR_CMD_B       8'haa
`define FCAD_CODE_UNLOCK1     8'haa
`define FCAD_CODE_UNLOCK2     8'h55
`define FCAD_CODE_RESET       8'hf0
`define FCAD_CODE_PROG        8'ha0
`define FCAD_CODE_ERASE       8'h80
`define FCAD_CODE_CHIP        8'h10
`define FCAD_CODE_BLOCK       8'h30
`define FCAD_CODE_PROT_PROG   8'h9a
`define FCAD_CODE_PROT_ERASE  8'h6a

// ==========================================================================
// Field positions
// ==========================================================================
`define FCAD_CMD_HI           15
`define FCAD_CMD_LO           8
`define FCAD_REGION_HI        31
`define FCAD_REGION_LO        19
`define FCAD_PBA_FIX_HI       16
`define FCAD_PBA_FIX_LO       11

// ==========================================================================
// Block map
// ==========================================================================
`define FCAD_USER_REGION      13'h0000
`define FCAD_SINGLE_REGION    13'h07f0
`define FCAD_SINGLE_B0_START  19'h68000
`define FCAD_NUM_BLOCKS       6
`define FCAD_MAX_PROT_BLOCK   3'h5
`define FCAD_GROUP_LOW        6'h0f
`define FCAD_GROUP_HIGH       6'h30
`define FCAD_ALL_BLOCKS       6'h3f

// ==========================================================================
// Page and reset values
// ==========================================================================
`define FCAD_PAGE_WORDS       2'h3
`define FCAD_DONE_RESET       1'b1

`endif

// >>> core/fcad_pkg.sv
// Purpose: Types shared by the flash command address decoder.
// Assumes: Nothing beyond the constants header.
// Notes:   States carry no explicit codes.
package fcad_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_W2, ST_W3, ST_W4, ST_W5, ST_W6, ST_W7, ST_PAGE
    } fcad_state_type;

    typedef enum logic [2:0] {
        OP_NONE, OP_PAGE_PROG, OP_CHIP_ERASE, OP_BLOCK_ERASE, OP_PROT_PROG, OP_PROT_ERASE
    } fcad_op_type;

    // One-hot mask of a block number, zero when out of range.
    function automatic logic [5:0] fcad_onehot(input logic [2:0] num);
        logic [5:0] m;
        m = 6'h00;
        if (num < 3'h6) begin
            m[num] = 1'b1;
        end
        return m;
    endfunction

endpackage

// >>> core/fcad_blk_map.sv
// Purpose: Maps a byte address to a flash erase block in either boot mode.
// Assumes: Only the upper address bits separate the blocks.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "fcad_cfg.svh"

module fcad_blk_map
    import fcad_pkg::*;
(
    // Address and boot mode in
    input  wire logic [31:0] addr,
    input  wire logic        singleBoot,
    // Decoded block
    output      logic        blkHit,
    output      logic [2:0]  blkNum
);
    wire logic [12:0] region    = addr[`FCAD_REGION_HI:`FCAD_REGION_LO];
    wire logic [18:0] offset    = addr[18:0];
    wire logic [3:0]  upper     = offset[18:15];
    wire logic        inUser    = !singleBoot && (region == `FCAD_USER_REGION);
    wire logic        inSingle  = singleBoot && (region == `FCAD_SINGLE_REGION);
    wire logic        inGapB0   = singleBoot && (upper[3:2] == 2'h3) && (offset < `FCAD_SINGLE_B0_START);

    // Order from the base upward is 4, 5, 3, 2, 1, 0.
    assign blkNum = (upper == 4'h0)       ? 3'h4 :
                    (upper == 4'h1)       ? 3'h5 :
                    (upper[3:1] == 3'h1)  ? 3'h3 :
                    (upper[3:2] == 2'h1)  ? 3'h2 :
                    (upper[3:2] == 2'h2)  ? 3'h1 : 3'h0;
    // The printed start of block 0 in single boot mode is kept as given.
    assign blkHit = (inUser || inSingle) && !inGapB0;

endmodule // fcad_blk_map

// >>> tb/fcad_cpu_model.sv
// Purpose: CPU side model that issues flash command sequences as word writes.
// Assumes: One write per clock, driven 1 ns after the rising edge.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps

module fcad_cpu_model
    import fcad_pkg::*;
(
    // Clock and status
    input  wire logic        mclk,
    input  wire logic        ready,
    // Write port
    output      logic        wrEn,
    output      logic [31:0] wrAddr,
    output      logic [31:0] wrData
);
    logic [7:0] aByte;
    logic       waive;

    initial begin
        wrEn   = 1'b0;
        wrAddr = 32'h0000_0000;
        wrData = 32'h0000_0000;
        aByte  = 8'h54;
        waive  = 1'b0;
    end

    // ==========================================================================
    // Bus cycles
    // ==========================================================================
    task automatic write_raw(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        #1;
        wrEn   = 1'b1;
        wrAddr = a;
        wrData = d;
    endtask

    task automatic write_word(input logic [31:0] a, input logic [31:0] d);
        write_raw({a[31:2], 2'h0}, d);
    endtask

    task automatic idle();
        @(posedge mclk);
        #1;
        wrEn   = 1'b0;
        wrAddr = ~wrAddr;
        wrData = ~wrData;
    endtask

    // ==========================================================================
    // Command sequences
    // ==========================================================================
    // The ready wait is skipped only when a scenario asks for a busy write.
    task automatic pre(input logic [31:0] up);
        int k;
        for (k = 0; k < 100 && waive !== 1'b1 && ready !== 1'b1; k++) begin
            @(posedge mclk);
        end
        write_word({up[31:16], aByte, 8'h00}, 32'h0000_00aa);
        write_word({up[31:16], 8'haa, 8'h00}, 32'h0000_0055);
    endtask

    task automatic unlock(input logic [31:0] up, input logic [7:0] code);
        pre(up);
        write_word({up[31:16], aByte, 8'h00}, {24'h000000, code});
    endtask

    task automatic block_erase(input logic [31:0] ba);
        unlock(ba, 8'h80);
        pre(ba);
        write_word(ba, 32'h0000_0030);
    endtask

    task automatic chip_erase();
        unlock(32'h0000_0000, 8'h80);
        unlock(32'h0000_0000, 8'h10);
    endtask

    task automatic prot(input logic [7:0] code, input logic [31:0] protect_bit_addr);
        unlock(32'h0000_0000, code);
        unlock(32'h0000_0000, code);
        write_word(protect_bit_addr, {24'h000000, code});
    endtask

    task automatic page(input logic [31:0] pa, input logic [31:0] d [4]);
        int i;
        unlock(32'h0000_0000, 8'ha0);
        for (i = 0; i < 4; i++) begin
            write_word(pa + 4 * i, d[i]);
        end
    endtask
endmodule // fcad_cpu_model

// >>> tb/fcad_decoder_tb.sv
// Purpose: Self-checking bench for the flash command address decoder.
// Assumes: Array engine status is driven by the bench.
// Notes:   Outputs are sampled a little after the edge that registers them.
`timescale 1ns/1ps

module fcad_decoder_tb
    import fcad_pkg::*;
;
    logic        mclk, resetn, clkEn, singleBoot, opDone, opFail, wrEn;
    logic [31:0] wrAddr, wrData, program_page_addr, pageWordAddr, pageWordData;
    logic        readReset, opStart, pageWordValid, auto_op_done_flag;
    logic [5:0]  opBlockMask;
    fcad_op_type opKind;
    int          nMismatch, samplesChecked;

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    fcad_decoder fcad_decoder_i (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .wrEn(wrEn), .wrAddr(wrAddr),
        .wrData(wrData), .singleBoot(singleBoot), .opDone(opDone), .opFail(opFail), .readReset(readReset),
        .opStart(opStart), .opKind(opKind), .opBlockMask(opBlockMask), .program_page_addr(program_page_addr),
        .pageWordValid(pageWordValid), .pageWordAddr(pageWordAddr), .pageWordData(pageWordData),
        .auto_op_done_flag(auto_op_done_flag));

    fcad_cpu_model fcad_cpu_model_i (.mclk(mclk), .ready(auto_op_done_flag), .wrEn(wrEn), .wrAddr(wrAddr),
        .wrData(wrData));

    // ==========================================================================
    // Checking helpers
    // ==========================================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // After a failure the flag must stay low even when the engine reports done.
    task automatic finish_op(input logic exp = 1'b1);
        @(posedge mclk);
        #1;
        opDone = 1'b1;
        @(posedge mclk);
        #1;
        opDone = 1'b0;
        check("doneFlag", auto_op_done_flag, {31'h0, exp});
    endtask

    task automatic expect_op(input fcad_op_type k, input logic [5:0] m);
        fcad_cpu_model_i.idle();
        check("opStart", opStart, 32'h1);
        check("opKind", opKind, k);
        check("opBlockMask", opBlockMask, m);
        check("doneFlag", auto_op_done_flag, 32'h0);
        finish_op();
    endtask

    task automatic expect_none();
        fcad_cpu_model_i.idle();
        check("opStart", opStart, 32'h0);
        check("doneFlag", auto_op_done_flag, 32'h1);
    endtask

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic test_reset();
        check("doneFlag", auto_op_done_flag, 32'h1);
        check("opKind", opKind, OP_NONE);
        check("opBlockMask", opBlockMask, 32'h0);
    endtask

    task automatic test_chip_refuse();
        fcad_cpu_model_i.unlock(32'h0000_0000, 8'hf0);
        fcad_cpu_model_i.idle();
        check("readReset", readReset, 32'h1);
        fcad_cpu_model_i.chip_erase();
        expect_op(OP_CHIP_ERASE, 6'h3f);
        fcad_cpu_model_i.unlock(32'h0004_0000, 8'h80);
        fcad_cpu_model_i.write_raw(32'h0000_5402, 32'h0000_0010);
        fcad_cpu_model_i.write_word(32'h0000_5400, 32'h0000_0010);
        clkEn = 1'b0;
        fork
            fcad_cpu_model_i.pre(32'h0004_0000);
            begin
                @(posedge mclk);
                #1;
                clkEn = 1'b1;
            end
        join
        fcad_cpu_model_i.write_word(32'h0005_1234, 32'h0000_0030);
        expect_op(OP_BLOCK_ERASE, 6'h02);
        fcad_cpu_model_i.chip_erase();
        fcad_cpu_model_i.idle();
        check("doneFlag", auto_op_done_flag, 32'h0);
        fcad_cpu_model_i.waive = 1'b1;
        fcad_cpu_model_i.block_erase(32'h0000_0000);
        fcad_cpu_model_i.idle();
        check("opStart", opStart, 32'h0);
        check("opKind", opKind, OP_CHIP_ERASE);
        @(posedge mclk);
        #1;
        opFail = 1'b1;
        @(posedge mclk);
        #1;
        opFail = 1'b0;
        finish_op(1'b0);
        fcad_cpu_model_i.chip_erase();
        fcad_cpu_model_i.idle();
        check("opStart", opStart, 32'h0);
        check("doneFlag", auto_op_done_flag, 32'h0);
        resetn = 1'b0;
        @(posedge mclk);
        #1;
        check("doneFlag", auto_op_done_flag, 32'h1);
        check("opKind", opKind, OP_NONE);
        resetn = 1'b1;
        fcad_cpu_model_i.waive = 1'b0;
        fcad_cpu_model_i.chip_erase();
        expect_op(OP_CHIP_ERASE, 6'h3f);
    endtask

    task automatic test_block_map();
        logic [31:0] uAddr [6] = '{32'h0000_7ffc, 32'h0000_8000, 32'h0001_fffc, 32'h0002_0000, 32'h0005_fffc,
                                   32'h0006_0000};
        int          num [6] = '{4, 5, 3, 2, 1, 0};
        logic [31:0] a;
        for (int i = 0; i < 6; i++) begin
            for (int m = 0; m < 2; m++) begin
                singleBoot = (m == 1);
                fcad_cpu_model_i.aByte = (i % 2 == 1) ? 8'h55 : 8'h54;
                a = (m == 1) ? (32'h3f80_0000 | uAddr[i]) : uAddr[i];
                if (m == 1 && i == 5) begin
                    a = 32'h3f86_8000;
                end
                fcad_cpu_model_i.block_erase(a);
                expect_op(OP_BLOCK_ERASE, 6'h01 << num[i]);
            end
        end
        fcad_cpu_model_i.block_erase(32'h3f86_0000);
        expect_none();
        singleBoot = 1'b0;
        fcad_cpu_model_i.block_erase(32'h0008_0000);
        expect_none();
    endtask

    task automatic test_page();
        logic [31:0] d [4] = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003, 32'h4444_0004};
        logic [31:0] pa = 32'h0001_00c0;
        int          n;
        fork
            begin
                fcad_cpu_model_i.page(pa, d);
                fcad_cpu_model_i.idle();
            end
            for (int k = 0; k < 30 && n < 4; k++) begin
                @(posedge mclk);
                #2;
                if (pageWordValid === 1'b1) begin
                    check("pageWordAddr", pageWordAddr, pa + 4 * n);
                    check("pageWordData", pageWordData, d[n]);
                    if (n == 3) check("opStart", opStart, 32'h1);
                    n++;
                end
            end
        join
        check("pageWords", n, 32'h4);
        check("program_page_addr", program_page_addr, pa);
        check("opKind", opKind, OP_PAGE_PROG);
        finish_op();
    endtask

    task automatic test_prot();
        logic [2:0] b;
        for (int n = 0; n < 8; n++) begin
            b = n[2:0];
            fcad_cpu_model_i.prot(8'h9a, {14'h0000, b[2], 6'h00, b[1], b[0], 9'h100});
            if (n < 6) expect_op(OP_PROT_PROG, 6'h01 << n);
            else expect_none();
        end
        fcad_cpu_model_i.prot(8'h9a, 32'h0001_0000);
        expect_none();
        fcad_cpu_model_i.prot(8'h6a, 32'h0000_0600);
        expect_op(OP_PROT_ERASE, 6'h0f);
        fcad_cpu_model_i.prot(8'h6a, 32'h0002_0200);
        expect_op(OP_PROT_ERASE, 6'h30);
        fcad_cpu_model_i.prot(8'h6a, 32'h0004_0000);
        expect_none();
    endtask

    // ==========================================================================
    // Main sequence and watchdog
    // ==========================================================================
    initial begin
        resetn = 1'b0;
        clkEn = 1'b1;
        singleBoot = 1'b0;
        opDone = 1'b0;
        opFail = 1'b0;
        nMismatch = 0;
        samplesChecked = 0;
        repeat (4) @(posedge mclk);
        #1;
        resetn = 1'b1;
        test_reset();
        test_chip_refuse();
        test_block_map();
        test_page();
        test_prot();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        nMismatch++;
        report_and_stop();
    end
endmodule // fcad_decoder_tb
